// ===== design/move_arith_datapath.sv
/*
  Execution datapath for data moves, stack push/pop, byte and word
  arithmetic and byte logic, with its own register file and flags.
  Assumes a sequencer that pulses start with a decoded operation and
  a data memory answering each strobe with a one-cycle memAck.
*/
`timescale 1ns/1ns
`default_nettype none
module move_arith_datapath (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 start,    // Operation request
  input  wire move_arith_pkg::op_t  op,
  input  wire move_arith_pkg::am_t  mode,     // Move addressing mode
  input  wire logic                 isWord,   // Word operand size
  input  wire logic                 toMem,    // Move stores to memory
  input  wire logic                 srcImm,   // Source is immediate
  input  wire logic [3:0]           rd,       // Destination index
  input  wire logic [3:0]           rs,       // Source index
  input  wire logic [15:0]          ext,      // Immediate/disp/address
  input  wire logic [15:0]          memRdata,
  input  wire logic                 memAck,
  input  wire logic [2:0]           obsSel,   // Register readback
  output logic [15:0]               obsData,
  output logic [15:0]               memAddr,
  output logic [15:0]               memWdata,
  output logic                      memRd,
  output logic                      memWr,
  output logic                      memWord,
  output logic [7:0]                condFlags,
  output logic                      busy,
  output logic                      done,
  output logic                      illegal
);
  import move_arith_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte view: index bit 3 picks the low half of the word
  function automatic logic [7:0] byteOf(input logic [15:0] w,
                                        input logic lo);
    byteOf = lo ? w[7:0] : w[15:8];
  endfunction

  function automatic logic [15:0] setByte(input logic [15:0] w,
                                          input logic lo,
                                          input logic [7:0] b);
    setByte = lo ? {w[15:8], b} : {b, w[7:0]};
  endfunction

  // Add or subtract with carry/borrow in; flags per width
  function automatic ar_t arith(input logic [15:0] a, b,
                                input logic cin, sub, wd);
    ar_t         o;
    logic [15:0] bb;
    logic        ci;
    logic [16:0] s;
    logic [12:0] s12;
    logic [4:0]  s4;
    logic [8:0]  s8;
    bb  = sub ? ~b : b;
    ci  = sub ? ~cin : cin;
    s   = {1'b0, a} + {1'b0, bb} + {16'h0000, ci};
    s12 = {1'b0, a[11:0]} + {1'b0, bb[11:0]} + {12'h000, ci};
    s4  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    s8  = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, ci};
    o.r = wd ? s[15:0] : {8'h00, s8[7:0]};
    o.n = wd ? s[15] : s8[7];
    o.z = wd ? (s[15:0] == 16'h0000) : (s8[7:0] == 8'h00);
    o.v = wd ? (a[15] == bb[15]) && (s[15] != a[15])
             : (a[7] == bb[7]) && (s8[7] != a[7]);
    o.c = (wd ? s[16] : s8[8]) ^ sub;
    o.h = (wd ? s12[12] : s4[4]) ^ sub;
    arith = o;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] regs_r [8];             // General registers, 7 = stack
  logic [15:0] regs_nxt [8];
  logic [7:0]  flags_r, flags_nxt;     // Condition flags
  state_t      state_r, state_nxt;
  logic [15:0] memAddr_r, memAddr_nxt;
  logic [15:0] memWdata_r, memWdata_nxt;
  logic        memRd_r, memRd_nxt;
  logic        memWr_r, memWr_nxt;
  logic        memWord_r, memWord_nxt;
  logic [3:0]  ldIdx_r, ldIdx_nxt;     // Load destination, held
  logic        done_r, done_nxt;
  logic        illegal_r, illegal_nxt;
  logic [15:0] obs_r;

  // Operand views shared by the operation decode
  logic [7:0]  aB, bB;
  logic [15:0] aW, bW;
  assign aB = byteOf(regs_r[rd[2:0]], rd[3]);
  assign bB = srcImm ? ext[7:0] : byteOf(regs_r[rs[2:0]], rs[3]);
  assign aW = regs_r[rd[2:0]];
  assign bW = regs_r[rs[2:0]];

  // ---------------------------------------------------------------
  // Next-state computation
  // ---------------------------------------------------------------
  // One process so every operation sees a single register image
  always_comb begin
    ar_t         ar;
    logic [15:0] base, ea, step, q16;
    logic [7:0]  lb;
    logic        w, st;
    logic [2:0]  ptr;
    am_t         m;
    ar = '0; base = '0; ea = '0; step = STEP_BYTE; q16 = '0;
    lb = '0; w = 1'b0; st = 1'b0; ptr = SP_IDX; m = AM_REG;
    regs_nxt     = regs_r;
    flags_nxt    = flags_r;
    state_nxt    = state_r;
    memAddr_nxt  = memAddr_r;
    memWdata_nxt = memWdata_r;
    memRd_nxt    = memRd_r;
    memWr_nxt    = memWr_r;
    memWord_nxt  = memWord_r;
    ldIdx_nxt    = ldIdx_r;
    done_nxt     = 1'b0;
    illegal_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: if (start) begin
        done_nxt = 1'b1;
        case (op)
          // data moves, push and pop share one path
          OP_MOVE, OP_PUSH, OP_POP: begin
            // stack forms are word moves on register 7
            m   = (op == OP_PUSH) ? AM_PREDEC :
                  (op == OP_POP) ? AM_POSTINC : mode;
            st  = (op == OP_PUSH) || (op == OP_MOVE && toMem);
            w   = (op != OP_MOVE) || isWord;
            ptr = (op != OP_MOVE) ? SP_IDX : (st ? rd[2:0] : rs[2:0]);
            step = w ? STEP_WORD : STEP_BYTE;
            base = regs_nxt[ptr];
            // short absolute for bytes; no immediate store
            if ((w && m == AM_ABS8) || (st && m == AM_IMM)) begin
              illegal_nxt = 1'b1;
            end else if (m == AM_REG || m == AM_IMM) begin
              lb = (m == AM_IMM) ? ext[7:0] : byteOf(bW, rs[3]);
              q16 = (m == AM_IMM) ? ext : bW;
              if (w) regs_nxt[rd[2:0]] = q16;
              else regs_nxt[rd[2:0]] = setByte(aW, rd[3], lb);
              flags_nxt[FL_N] = w ? q16[15] : lb[7];
              flags_nxt[FL_Z] = w ? (q16 == 16'h0000) : (lb == 8'h00);
              flags_nxt[FL_V] = 1'b0;
            end else begin
              case (m)
                AM_DISP:   ea = base + ext;
                AM_ABS16:  ea = ext;
                // short absolute lands in the top page
                AM_ABS8:   ea = {ABS8_PAGE, ext[7:0]};
                AM_PREDEC: ea = base - step;
                default:   ea = base;
              endcase
              // pointer takes its new value at acceptance
              if (m == AM_PREDEC) regs_nxt[ptr] = base - step;
              if (m == AM_POSTINC) regs_nxt[ptr] = base + step;
              // odd word address falls to the even one below
              memAddr_nxt  = w ? {ea[15:1], 1'b0} : ea;
              memWdata_nxt = w ? bW : {8'h00, byteOf(bW, rs[3])};
              memWord_nxt  = w;
              memRd_nxt    = !st;
              memWr_nxt    = st;
              ldIdx_nxt    = rd;
              done_nxt     = 1'b0;
              state_nxt    = ST_WAIT;
            end
          end
          // immediate add is byte only; subtract never
          OP_ADD, OP_SUB: begin
            if (srcImm && (isWord || op == OP_SUB)) begin
              illegal_nxt = 1'b1;
            end else begin
              ar = isWord ? arith(aW, bW, 1'b0, op == OP_SUB, 1'b1)
                 : arith({8'h00, aB}, {8'h00, bB}, 1'b0,
                         op == OP_SUB, 1'b0);
            end
          end
          // byte forms that fold in the carry flag
          OP_ADDC, OP_SUBB:
            ar = arith({8'h00, aB}, {8'h00, bB}, flags_r[FL_C],
                       op == OP_SUBB, 1'b0);
          // plus or minus one on a byte register
          OP_INC, OP_DOWN:
            ar = arith({8'h00, aB}, 16'h0001, 1'b0, op == OP_DOWN, 1'b0);
          // step of one or two on a word, flags untouched
          OP_ADDSM, OP_SUBSM: begin
            step = ext[1] ? STEP_WORD : STEP_BYTE;
            regs_nxt[rd[2:0]] = (op == OP_ADDSM) ? aW + step : aW - step;
          end
          // packed decimal correction from C and H
          OP_DADJA, OP_DADJS: begin
            lb = 8'h00;
            if (flags_r[FL_H] || (op == OP_DADJA && aB[3:0] > 4'h9))
              lb[3:0] = 4'h6;
            if (flags_r[FL_C] || (op == OP_DADJA && aB > 8'h99))
              lb[7:4] = 4'h6;
            ar = arith({8'h00, aB}, {8'h00, lb}, 1'b0,
                       op == OP_DADJS, 1'b0);
            ar.c = (lb[7:4] != 4'h0);
            ar.v = 1'b0;
          end
          // byte times byte into the whole word register
          OP_MUL: regs_nxt[rd[2:0]] = 16'(aW[7:0] * bB);
          // quotient low byte, remainder high byte
          OP_DIV: begin
            flags_nxt[FL_N] = bB[7];
            flags_nxt[FL_Z] = (bB == 8'h00);
            // Zero divisor leaves the destination alone
            if (bB != 8'h00) begin
              q16 = aW / {8'h00, bB};
              lb  = 8'(aW % {8'h00, bB});
              regs_nxt[rd[2:0]] = {lb, q16[7:0]};
            end
          end
          // flags only; word compare needs two registers
          OP_CMPR: begin
            if (srcImm && isWord) illegal_nxt = 1'b1;
            else ar = isWord ? arith(aW, bW, 1'b0, 1'b1, 1'b1)
                    : arith({8'h00, aB}, {8'h00, bB}, 1'b0, 1'b1, 1'b0);
          end
          OP_NEGT: ar = arith(16'h0000, {8'h00, aB}, 1'b0, 1'b1, 1'b0);
          OP_AND: ar.r = {8'h00, aB & bB};
          OP_OR:  ar.r = {8'h00, aB | bB};
          OP_XOR: ar.r = {8'h00, aB ^ bB};
          OP_NOT: ar.r = {8'h00, ~aB};
          default: illegal_nxt = 1'b1;
        endcase
        if (!illegal_nxt) begin
          case (op)
            OP_ADD, OP_SUB, OP_ADDC, OP_SUBB, OP_CMPR, OP_NEGT,
            OP_DADJA, OP_DADJS, OP_INC, OP_DOWN: begin
              flags_nxt[FL_N] = ar.n;
              flags_nxt[FL_V] = ar.v;
              flags_nxt[FL_Z] = ar.z;
              // Carry chains keep a zero flag cleared by a low half
              if (op == OP_ADDC || op == OP_SUBB)
                flags_nxt[FL_Z] = ar.z && flags_r[FL_Z];
              if (op != OP_INC && op != OP_DOWN) begin
                flags_nxt[FL_C] = ar.c;
                flags_nxt[FL_H] = ar.h;
              end
              if (op == OP_CMPR) ;
              else if (isWord && (op == OP_ADD || op == OP_SUB))
                regs_nxt[rd[2:0]] = ar.r;
              else regs_nxt[rd[2:0]] = setByte(aW, rd[3], ar.r[7:0]);
            end
            OP_AND, OP_OR, OP_XOR, OP_NOT: begin
              flags_nxt[FL_N] = ar.r[7];
              flags_nxt[FL_Z] = (ar.r[7:0] == 8'h00);
              flags_nxt[FL_V] = 1'b0;
              regs_nxt[rd[2:0]] = setByte(aW, rd[3], ar.r[7:0]);
            end
            default: ;
          endcase
        end
      end
      // Memory access in flight; load data lands on the answer
      ST_WAIT: if (memAck) begin
        memRd_nxt = 1'b0;
        memWr_nxt = 1'b0;
        done_nxt  = 1'b1;
        state_nxt = ST_IDLE;
        if (memRd_r) begin
          lb = memRdata[7:0];
          if (memWord_r) regs_nxt[ldIdx_r[2:0]] = memRdata;
          else regs_nxt[ldIdx_r[2:0]] =
                 setByte(regs_r[ldIdx_r[2:0]], ldIdx_r[3], lb);
          flags_nxt[FL_N] = memWord_r ? memRdata[15] : lb[7];
          flags_nxt[FL_Z] = memWord_r ? (memRdata == 16'h0000)
                                      : (lb == 8'h00);
        end
        flags_nxt[FL_V] = 1'b0;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) regs_r[i] <= REG_RST;
      flags_r    <= FLAGS_RST;
      state_r    <= ST_IDLE;
      memAddr_r  <= ADDR_RST;
      memWdata_r <= REG_RST;
      memRd_r    <= 1'b0;
      memWr_r    <= 1'b0;
      memWord_r  <= 1'b0;
      ldIdx_r    <= 4'h0;
      done_r     <= 1'b0;
      illegal_r  <= 1'b0;
      obs_r      <= REG_RST;
    end else begin
      regs_r     <= regs_nxt;
      flags_r    <= flags_nxt;
      state_r    <= state_nxt;
      memAddr_r  <= memAddr_nxt;
      memWdata_r <= memWdata_nxt;
      memRd_r    <= memRd_nxt;
      memWr_r    <= memWr_nxt;
      memWord_r  <= memWord_nxt;
      ldIdx_r    <= ldIdx_nxt;
      done_r     <= done_nxt;
      illegal_r  <= illegal_nxt;
      obs_r      <= regs_nxt[obsSel];
    end
  end

  assign obsData   = obs_r;
  assign memAddr   = memAddr_r;
  assign memWdata  = memWdata_r;
  assign memRd     = memRd_r;
  assign memWr     = memWr_r;
  assign memWord   = memWord_r;
  assign condFlags = flags_r;
  assign busy      = (state_r == ST_WAIT);
  assign done      = done_r;
  assign illegal   = illegal_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence sTake(op_t o);
    state_r == ST_IDLE && start && op == o;
  endsequence

  a_push_sp_down: assert property (sTake(OP_PUSH) |=>
    regs_r[7] == $past(regs_r[7]) - 16'h0002 && memWr_r
    && memAddr_r == ($past(regs_r[7]) - 16'h0002 & 16'hFFFE))
    else $error("push pointer or address wrong");
  a_pop_sp_up: assert property (sTake(OP_POP) |=>
    regs_r[7] == $past(regs_r[7]) + 16'h0002 && memRd_r
    && memAddr_r == ($past(regs_r[7]) & 16'hFFFE))
    else $error("pop pointer or address wrong");
  a_word_even: assert property ((memRd_r || memWr_r) && memWord_r
    |-> !memAddr_r[0]) else $error("odd word address");
  a_abs8_page: assert property (sTake(OP_MOVE) && mode == AM_ABS8
    && !isWord |=> memAddr_r[15:8] == 8'hFF)
    else $error("short absolute outside top page");
  a_cmp_keeps: assert property (sTake(OP_CMPR) |=>
    regs_r[$past(rd[2:0])] == $past(aW) && done_r)
    else $error("compare changed destination");
  a_sub_imm_ref: assert property (sTake(OP_SUB) && srcImm
    |=> illegal_r && regs_r[$past(rd[2:0])] == $past(aW))
    else $error("subtract immediate accepted");
  a_mul_prod: assert property (sTake(OP_MUL) |=>
    regs_r[$past(rd[2:0])] == $past(aW[7:0]) * $past(bB))
    else $error("product wrong");
  // A new request taken right after the answer may pulse done again
  a_mem_finish: assert property (memRd_r && memAck
    |=> !memRd_r && done_r ##1 (!done_r || $past(start)))
    else $error("memory answer not finished");

endmodule
`default_nettype wire

// ===== include/move_arith_pkg.sv
/*
  Shared constants and types for the move, arithmetic and logic
  datapath: operation and addressing-mode codes, flag positions,
  reset values and the arithmetic result layout.
  Assumes a single core clock and one sequencer issuing operations.
*/
package move_arith_pkg;

  // ---------------------------------------------------------------
  // Operations
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_MOVE, OP_PUSH, OP_POP, OP_ADD, OP_SUB, OP_ADDC, OP_SUBB,
    OP_INC, OP_DOWN, OP_ADDSM, OP_SUBSM, OP_DADJA, OP_DADJS,
    OP_MUL, OP_DIV, OP_CMPR, OP_NEGT, OP_AND, OP_OR, OP_XOR, OP_NOT
  } op_t;

  // ---------------------------------------------------------------
  // Addressing modes of the move operation
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    AM_REG, AM_IND, AM_DISP, AM_ABS16, AM_ABS8, AM_IMM, AM_PREDEC,
    AM_POSTINC
  } am_t;

  // ---------------------------------------------------------------
  // Sequencer states (Gray order)
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_WAIT = 1'b1} state_t;

  // Arithmetic result with its flags
  typedef struct packed {
    logic        h;
    logic        n;
    logic        z;
    logic        v;
    logic        c;
    logic [15:0] r;
  } ar_t;

  localparam int         FL_C       = 0;      // Carry / borrow
  localparam int         FL_V       = 1;      // Signed overflow
  localparam int         FL_Z       = 2;      // Zero
  localparam int         FL_N       = 3;      // Negative
  localparam int         FL_H       = 5;      // Half carry
  localparam logic [2:0] SP_IDX     = 3'h7;   // Stack pointer register
  localparam logic [7:0] ABS8_PAGE  = 8'hFF;  // Short absolute page
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] REG_RST   = 16'h0000;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [15:0] ADDR_RST  = 16'h0000;

endpackage

// ===== sim/mem_model.sv
/*
  Data memory partner: byte array, words high byte first at memAddr.
  Assumes the strobes stand until memAck and one access at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  input  wire logic        memRd,
  input  wire logic        memWr,
  input  wire logic        memWord,
  input  wire logic [3:0]  memWait,
  output logic [15:0]      memRdata,
  output logic             memAck
);
  logic [7:0] mem [0:65535];  // Byte store, preloaded by the bench
  logic [3:0] cnt;            // Wait cycles spent on this strobe
  // ---------------------------------------------------------------
  // Answer
  // ---------------------------------------------------------------
  // Read data flips every cycle outside the ack, so a late sample of
  // the bus never matches by luck; the address is used as given, so
  // an odd word address from the block lands visibly wrong
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      memAck <= 1'b0;
      memRdata <= 16'hA5A5;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if ((memRd || memWr) && !memAck) begin
        if (cnt != memWait) begin
          cnt <= cnt + 4'h1;
        end else begin
          cnt <= 4'h0;
          memAck <= 1'b1;
          if (memWr && memWord) begin
            mem[memAddr] <= memWdata[15:8];
            mem[memAddr + 16'h0001] <= memWdata[7:0];
          end else if (memWr) begin
            mem[memAddr] <= memWdata[7:0];
          end else if (memWord) begin
            memRdata <= {mem[memAddr], mem[memAddr + 16'h0001]};
          end else begin
            memRdata <= {8'h00, mem[memAddr]};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/cpu_move_arith_logic_datapath_tb_top.sv
/*
  Self-checking bench for the move, arithmetic and logic datapath.
  Assumes the memory partner in mem_model and the shared package.
*/
`timescale 1ns/1ns
`default_nettype none
module cpu_move_arith_logic_datapath_tb_top;
  import move_arith_pkg::*;
  logic        clk, rstn, start, isWord, toMem, srcImm, memAck;
  logic        memRd, memWr, memWord, busy, done, illegal;
  op_t         op;
  am_t         mode;
  logic [3:0]  rd, rs, memWait;
  logic [2:0]  obsSel;
  logic [15:0] ext, memRdata, obsData, memAddr, memWdata;
  logic [7:0]  condFlags;
  int          n_errors, samples_checked;

  move_arith_datapath i_dut (.clk(clk), .rstn(rstn), .start(start),
    .op(op), .mode(mode), .isWord(isWord), .toMem(toMem),
    .srcImm(srcImm), .rd(rd), .rs(rs), .ext(ext), .memRdata(memRdata),
    .memAck(memAck), .obsSel(obsSel), .obsData(obsData),
    .memAddr(memAddr), .memWdata(memWdata), .memRd(memRd),
    .memWr(memWr), .memWord(memWord), .condFlags(condFlags),
    .busy(busy), .done(done), .illegal(illegal));
  mem_model i_mem (.clk(clk), .rstn(rstn), .memAddr(memAddr),
    .memWdata(memWdata), .memRd(memRd), .memWr(memWr),
    .memWord(memWord), .memWait(memWait), .memRdata(memRdata),
    .memAck(memAck));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One request, held a single cycle; completion waited on, bounded
  task automatic go(input op_t o, input am_t m, input logic w, t, i,
                    input logic [3:0] d, s, input logic [15:0] x,
                    input logic ill);
    int k;
    logic viaMem;
    // Memory forms of a move, and the stack forms, wait on the bus
    viaMem = !ill && (o == OP_PUSH || o == OP_POP ||
             (o == OP_MOVE && m != AM_REG && m != AM_IMM));
    @(negedge clk);
    op = o;
    mode = m;
    isWord = w;
    toMem = t;
    srcImm = i;
    rd = d;
    rs = s;
    ext = x;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk({15'h0000, busy}, {15'h0000, viaMem}, "busy");
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk({15'h0000, done}, 16'h0001, "done");
    chk({15'h0000, illegal}, {15'h0000, ill}, "illegal");
    chk({15'h0000, busy}, 16'h0000, "idle");
  endtask
  task automatic setReg(input logic [2:0] n, input logic [15:0] v);
    go(OP_MOVE, AM_IMM, 1'b1, 1'b0, 1'b0, {1'b0, n}, 4'h0, v, 1'b0);
  endtask
  task automatic chkReg(input logic [2:0] n, input logic [15:0] e,
                        input string what);
    @(negedge clk);
    obsSel = n;
    @(negedge clk);
    chk(obsData, e, what);
  endtask
  // Flags are {expected NZVC, mask}; kind is {immediate, word, refused}
  task automatic ar(input op_t o, input logic [2:0] kd,
                    input logic [15:0] a, b, x, e, input logic [7:0] f);
    setReg(3'h1, a);
    setReg(3'h2, b);
    go(o, AM_REG, kd[1], 1'b0, kd[2], kd[1] ? 4'h1 : 4'h9,
       kd[1] ? 4'h2 : 4'hA, x, kd[0]);
    chkReg(3'h1, e, "result");
    chk({12'h000, condFlags[3:0] & f[3:0]}, {12'h000, f[7:4] & f[3:0]},
        "flags");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_moves();
    i_mem.mem[16'h2000] = 8'h12;
    i_mem.mem[16'h2001] = 8'h34;
    i_mem.mem[16'h2002] = 8'h56;
    i_mem.mem[16'h2012] = 8'hCA;
    i_mem.mem[16'h2013] = 8'hFE;
    i_mem.mem[16'hFF40] = 8'h77;
    setReg(3'h3, 16'h1235);
    setReg(3'h4, 16'hBEEF);
    go(OP_MOVE, AM_IND, 1'b1, 1'b1, 1'b0, 4'h3, 4'h4, 16'h0000, 1'b0);
    chk({i_mem.mem[16'h1234], i_mem.mem[16'h1235]}, 16'hBEEF, "odd");
    setReg(3'h3, 16'h2000);
    go(OP_MOVE, AM_POSTINC, 1'b1, 1'b0, 1'b0, 4'h5, 4'h3, 16'h0000, 1'b0);
    chkReg(3'h5, 16'h1234, "wload");
    chkReg(3'h3, 16'h2002, "winc");
    go(OP_MOVE, AM_POSTINC, 1'b0, 1'b0, 1'b0, 4'hD, 4'h3, 16'h0000, 1'b0);
    chkReg(3'h5, 16'h1256, "bload");
    chkReg(3'h3, 16'h2003, "binc");
    go(OP_MOVE, AM_PREDEC, 1'b0, 1'b1, 1'b0, 4'h3, 4'hC, 16'h0000, 1'b0);
    chkReg(3'h3, 16'h2002, "bdec");
    chk({8'h00, i_mem.mem[16'h2002]}, 16'h00EF, "bstore");
    go(OP_MOVE, AM_ABS8, 1'b0, 1'b0, 1'b0, 4'hD, 4'h0, 16'h0040, 1'b0);
    chkReg(3'h5, 16'h1277, "abs8");
    go(OP_MOVE, AM_DISP, 1'b1, 1'b0, 1'b0, 4'h6, 4'h3, 16'h0010, 1'b0);
    chkReg(3'h6, 16'hCAFE, "disp");
    go(OP_MOVE, AM_REG, 1'b0, 1'b0, 1'b0, 4'h6, 4'hC, 16'h0000, 1'b0);
    chkReg(3'h6, 16'hEFFE, "regmove");
    go(OP_MOVE, AM_ABS16, 1'b1, 1'b0, 1'b0, 4'h6, 4'h0, 16'h2013, 1'b0);
    chkReg(3'h6, 16'hCAFE, "abs16");
    go(OP_MOVE, AM_ABS8, 1'b1, 1'b0, 1'b0, 4'h5, 4'h0, 16'h0040, 1'b1);
    go(OP_MOVE, AM_IMM, 1'b1, 1'b1, 1'b0, 4'h5, 4'h5, 16'h0000, 1'b1);
    chkReg(3'h5, 16'h1277, "kept");
  endtask
  // Stack traffic in word size only, with a slow memory
  task automatic t_stack();
    memWait = 4'h3;
    setReg(3'h7, 16'h3000);
    go(OP_PUSH, AM_REG, 1'b1, 1'b0, 1'b0, 4'h0, 4'h4, 16'h0000, 1'b0);
    chkReg(3'h7, 16'h2FFE, "spdec");
    chk({i_mem.mem[16'h2FFE], i_mem.mem[16'h2FFF]}, 16'hBEEF, "push");
    go(OP_POP, AM_REG, 1'b1, 1'b0, 1'b0, 4'h6, 4'h0, 16'h0000, 1'b0);
    chkReg(3'h6, 16'hBEEF, "pop");
    chkReg(3'h7, 16'h3000, "spinc");
    memWait = 4'h0;
  endtask
  task automatic t_arith();
    ar(OP_ADD, 3'h4, 16'h007F, 16'h0000, 16'h0001, 16'h0080, 8'hAF);
    ar(OP_ADD, 3'h2, 16'h7FFF, 16'h0001, 16'h0000, 16'h8000, 8'hAF);
    ar(OP_SUB, 3'h0, 16'h0010, 16'h0020, 16'h0000, 16'h00F0, 8'h9F);
    ar(OP_SUB, 3'h2, 16'h1234, 16'h1234, 16'h0000, 16'h0000, 8'h4F);
    ar(OP_ADD, 3'h7, 16'h1234, 16'h0000, 16'h0001, 16'h1234, 8'h00);
    ar(OP_SUB, 3'h5, 16'h0034, 16'h0000, 16'h0001, 16'h0034, 8'h00);
    ar(OP_ADD, 3'h4, 16'h00FF, 16'h0000, 16'h0001, 16'h0000, 8'h5F);
    ar(OP_ADDC, 3'h0, 16'h0010, 16'h0020, 16'h0000, 16'h0031, 8'h0F);
    ar(OP_SUBB, 3'h4, 16'h0031, 16'h0000, 16'h0010, 16'h0021, 8'h0F);
    ar(OP_INC, 3'h0, 16'h007F, 16'h0000, 16'h0000, 16'h0080, 8'hAE);
    ar(OP_DOWN, 3'h0, 16'h0080, 16'h0000, 16'h0000, 16'h007F, 8'h2E);
    ar(OP_ADDSM, 3'h2, 16'hFFFF, 16'h0000, 16'h0002, 16'h0001, 8'h00);
    ar(OP_SUBSM, 3'h2, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 8'h00);
    ar(OP_ADD, 3'h0, 16'h0009, 16'h0008, 16'h0000, 16'h0011, 8'h0F);
    ar(OP_DADJA, 3'h0, 16'h0011, 16'h0000, 16'h0000, 16'h0017, 8'h01);
    ar(OP_SUB, 3'h0, 16'h0020, 16'h0001, 16'h0000, 16'h001F, 8'h0F);
    ar(OP_DADJS, 3'h0, 16'h001F, 16'h0000, 16'h0000, 16'h0019, 8'h01);
    ar(OP_MUL, 3'h0, 16'h0010, 16'h0020, 16'h0000, 16'h0200, 8'h00);
    ar(OP_DIV, 3'h0, 16'h0107, 16'h0010, 16'h0000, 16'h0710, 8'h0C);
    ar(OP_CMPR, 3'h4, 16'h0005, 16'h0000, 16'h0005, 16'h0005, 8'h4F);
    ar(OP_CMPR, 3'h7, 16'h0005, 16'h0000, 16'h0005, 16'h0005, 8'h00);
    ar(OP_CMPR, 3'h2, 16'h0100, 16'h0200, 16'h0000, 16'h0100, 8'h9F);
    ar(OP_NEGT, 3'h0, 16'h0001, 16'h0000, 16'h0000, 16'h00FF, 8'h9F);
    ar(OP_AND, 3'h4, 16'h00F0, 16'h0000, 16'h003C, 16'h0030, 8'h0E);
    ar(OP_OR, 3'h0, 16'h00F0, 16'h000F, 16'h0000, 16'h00FF, 8'h8E);
    ar(OP_XOR, 3'h4, 16'h00FF, 16'h0000, 16'h00FF, 16'h0000, 8'h4E);
    ar(OP_NOT, 3'h0, 16'h0055, 16'h0000, 16'h0000, 16'h00AA, 8'h8E);
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run needs well under 3000 cycles
  initial begin
    repeat (6000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {rstn, start, isWord, toMem, srcImm} = 5'h00;
    op = OP_MOVE;
    mode = AM_REG;
    {rd, rs, memWait, obsSel} = 15'h0000;
    ext = 16'h0000;
    n_errors = 0;
    samples_checked = 0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    t_moves();
    $display("moves finished");
    t_stack();
    $display("stack finished");
    t_arith();
    $display("arithmetic finished");
    tally_and_finish();
  end
endmodule
`default_nettype wire
